/* File: design/uapm_top.sv */
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/10ps
`include "uapm_cfg.svh"

// Functional notes
// - A low strap during reset gives the four upper pins to general-purpose I/O, a high strap gives them to memory address bits [21:18].
// - The pin function is fixed on the first clock after reset is released and kept until the next reset.
// - The bus holders are on after reset and software turns them on or off with a bit in the external bus control register.
// - While holders are on and a pin is not driven, the pin is kept at the level it last drove.
// - In general-purpose mode all four pins are inputs after reset.
// - In memory mode the pins float during reset and are driven afterwards with the address on EXTERNAL_MEMORY_INTERFACE_ADDR_IN.
// - The pins float while reset is held, whichever function is chosen.
// - The pins float while the outside party holds the bus through the hold input.
// - During bus hold each memory clock keeps running when its float select bit is 0 and floats when it is 1.
// - The pins float in off mode, which the outside party enters with test reset low, emulation pin zero high and the emulation off pin low.
// - In general-purpose mode each pin is separately an input or an output.
module uapm_top #(
	parameter int PIN_W = 4,
	parameter int CLK_W = 2
) (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic SYS_RST_IN,
	// Register port
	input wire uapm_pkg::uapm_reg_req_t REG_REQ_IN,
	output logic [15:0] REG_RDATA_OUT,
	// Upper address pins
	input wire logic [3:0] A_PIN_IN,
	output uapm_pkg::uapm_pad_t A_PAD_OUT,
	// Strap, hold and emulation pins
	input wire logic BOOT_FUNCTION_STRAP_IN,
	input wire logic BUS_HOLD_IN,
	input wire logic TEST_RESET_N_IN,
	input wire logic EMULATION_PIN_ZERO_IN,
	input wire logic EMULATION_OFF_PIN_IN,
	// External memory interface side
	input wire logic [3:0] EXTERNAL_MEMORY_INTERFACE_ADDR_IN,
	input wire logic [1:0] MEM_CLOCK_SRC_IN,
	output uapm_pkg::uapm_clk_pad_t MEMORY_CLOCK_OUTPUT_OUT,
	// General-purpose side
	output logic [3:0] GP_IN_DATA_OUT,
	output logic PIN_FUNCTION_EXTERNAL_MEMORY_INTERFACE_OUT
);
	import uapm_pkg::*;

	localparam int SYNC_W = 9;
	localparam int SYNC_N = `UAPM_SYNC_STAGES;

	// The pad structs and the register fields are laid out for four pins and two clocks.
	if (PIN_W != 4) begin : g_chk_pin_w
		$error("uapm_top: PIN_W must be 4");
	end
	if (CLK_W != 2) begin : g_chk_clk_w
		$error("uapm_top: CLK_W must be 2");
	end
	// The agree filter reads the second and third stages by index.
	if (SYNC_N != 3) begin : g_chk_sync_n
		$error("uapm_top: the pin synchroniser must have three stages");
	end

	// Synchronised pin inputs: pins, strap, hold, test reset, emulation_pin_zero, emu off.
	logic [SYNC_W-1:0] sync_raw;
	logic [SYNC_W-1:0] sync_stage [SYNC_N];
	logic [SYNC_W-1:0] filt_reg;
	logic [3:0] pin_in_s;
	logic strap_s;
	logic hold_s;
	logic trst_n_s;
	logic emulation_pin_zero_s;
	logic emu_off_s;

	assign sync_raw = {A_PIN_IN, BOOT_FUNCTION_STRAP_IN, BUS_HOLD_IN,
		TEST_RESET_N_IN, EMULATION_PIN_ZERO_IN, EMULATION_OFF_PIN_IN};

	// The chain has no reset so that the strap level is already settled when reset is released.
	always_ff @(posedge CLK_IN) begin
		sync_stage[0] <= sync_raw;
		for (int s = 1; s < SYNC_N; s++) begin
			sync_stage[s] <= sync_stage[s-1];
		end
	end

	// A change is taken only once the second and third stages agree.
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++) begin : g_filt
			always_ff @(posedge CLK_IN) begin
				if (sync_stage[1][gi] == sync_stage[2][gi]) begin
					filt_reg[gi] <= sync_stage[2][gi];
				end
			end
		end
	endgenerate

	assign pin_in_s = filt_reg[8:5];
	assign strap_s = filt_reg[4];
	assign hold_s = filt_reg[3];
	assign trst_n_s = filt_reg[2];
	assign emulation_pin_zero_s = filt_reg[1];
	assign emu_off_s = filt_reg[0];

	// Function capture.
	uapm_state_t state_reg;
	uapm_fn_t fn_reg;

	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			state_reg <= UAPM_ST_CAPTURE;
		end else begin
			case (state_reg)
				UAPM_ST_CAPTURE: state_reg <= UAPM_ST_RUN;
				UAPM_ST_RUN: state_reg <= UAPM_ST_RUN;
				default: state_reg <= UAPM_ST_CAPTURE;
			endcase
		end
	end

	// The strap is read by a clocked process at the first edge after release, never by the reset itself.
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			fn_reg <= UAPM_FN_GPIO;
		end else if (state_reg == UAPM_ST_CAPTURE) begin
			fn_reg <= strap_s ? UAPM_FN_EXTERNAL_MEMORY_INTERFACE : UAPM_FN_GPIO;
		end
	end

	// Registers.
	logic holder_en_reg;
	logic [1:0] clk_float_reg;
	logic [3:0] gp_dir_reg;
	logic [3:0] gp_out_reg;
	logic [15:0] rdata_reg;

	function automatic logic hit(input uapm_reg_req_t r, input logic [3:0] ofs);
		hit = r.wr && (r.addr == ofs);
	endfunction : hit

	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			holder_en_reg <= `UAPM_RST_HOLDER_EN;
		end else if (hit(REG_REQ_IN, `UAPM_OFS_BUS_CTRL)) begin
			holder_en_reg <= REG_REQ_IN.wdata[`UAPM_BIT_HOLDER_EN];
		end
	end

	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			clk_float_reg <= {2{`UAPM_RST_CLK_FLOAT}};
		end else begin
			if (hit(REG_REQ_IN, `UAPM_OFS_MEM_CTRL_ONE)) begin
				clk_float_reg[0] <= REG_REQ_IN.wdata[`UAPM_BIT_CLK_FLOAT];
			end
			if (hit(REG_REQ_IN, `UAPM_OFS_MEM_CTRL_TWO)) begin
				clk_float_reg[1] <= REG_REQ_IN.wdata[`UAPM_BIT_CLK_FLOAT];
			end
		end
	end

	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			gp_dir_reg <= `UAPM_RST_GP_DIR;
		end else if (hit(REG_REQ_IN, `UAPM_OFS_GP_DIR)) begin
			gp_dir_reg <= REG_REQ_IN.wdata[3:0];
		end
	end

	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			gp_out_reg <= `UAPM_RST_GP_OUT;
		end else if (hit(REG_REQ_IN, `UAPM_OFS_GP_OUT)) begin
			gp_out_reg <= REG_REQ_IN.wdata[3:0];
		end
	end

	// Pin mode conditions.
	logic off_mode;
	logic running;
	logic float_all;

	assign off_mode = !trst_n_s && emulation_pin_zero_s && !emu_off_s;
	assign running = (state_reg == UAPM_ST_RUN);
	assign float_all = !running || hold_s || off_mode;

	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			rdata_reg <= 16'h0000;
		end else if (REG_REQ_IN.rd) begin
			case (REG_REQ_IN.addr)
				`UAPM_OFS_BUS_CTRL: rdata_reg <= {15'h0000, holder_en_reg};
				`UAPM_OFS_MEM_CTRL_ONE: rdata_reg <= {15'h0000, clk_float_reg[0]};
				`UAPM_OFS_MEM_CTRL_TWO: rdata_reg <= {15'h0000, clk_float_reg[1]};
				`UAPM_OFS_GP_DIR: rdata_reg <= {12'h000, gp_dir_reg};
				`UAPM_OFS_GP_OUT: rdata_reg <= {12'h000, gp_out_reg};
				`UAPM_OFS_GP_IN: rdata_reg <= {12'h000, pin_in_s};
				`UAPM_OFS_STATUS: rdata_reg <= {12'h000, running, off_mode, hold_s, fn_reg == UAPM_FN_EXTERNAL_MEMORY_INTERFACE};
				default: rdata_reg <= 16'h0000;
			endcase
		end else begin
			rdata_reg <= 16'h0000;
		end
	end

	// Pad drive.
	logic [3:0] pad_drive_next;
	logic [3:0] pad_en_next;
	logic [3:0] pad_drive_reg;
	logic [3:0] pad_en_reg;
	logic [3:0] pad_keep_reg;

	always_comb begin
		pad_drive_next = pad_drive_reg;
		pad_en_next = 4'h0;
		if (!float_all) begin
			if (fn_reg == UAPM_FN_EXTERNAL_MEMORY_INTERFACE) begin
				pad_en_next = 4'hF;
				pad_drive_next = EXTERNAL_MEMORY_INTERFACE_ADDR_IN;
			end else begin
				pad_en_next = gp_dir_reg;
				// Input pins keep their old level so a later hold still restores what was last driven.
				pad_drive_next = (gp_out_reg & gp_dir_reg) | (pad_drive_reg & ~gp_dir_reg);
			end
		end
	end

	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			pad_drive_reg <= `UAPM_RST_EXTERNAL_MEMORY_INTERFACE_OUT;
			pad_en_reg <= 4'h0;
			pad_keep_reg <= {4{`UAPM_RST_HOLDER_EN}};
		end else begin
			pad_drive_reg <= pad_drive_next;
			pad_en_reg <= pad_en_next;
			pad_keep_reg <= {4{holder_en_reg}} & ~pad_en_next;
		end
	end

	// Memory clock pads.
	logic [1:0] clk_drive_reg;
	logic [1:0] clk_en_reg;

	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			clk_drive_reg <= 2'h0;
			clk_en_reg <= 2'h0;
		end else begin
			clk_drive_reg <= MEM_CLOCK_SRC_IN;
			if (!running || off_mode) begin
				clk_en_reg <= 2'h0;
			end else if (hold_s) begin
				clk_en_reg <= ~clk_float_reg;
			end else begin
				clk_en_reg <= 2'h3;
			end
		end
	end

	assign A_PAD_OUT.drive = pad_drive_reg;
	assign A_PAD_OUT.enable = pad_en_reg;
	assign A_PAD_OUT.keep = pad_keep_reg;
	assign MEMORY_CLOCK_OUTPUT_OUT.drive = clk_drive_reg;
	assign MEMORY_CLOCK_OUTPUT_OUT.enable = clk_en_reg;
	assign REG_RDATA_OUT = rdata_reg;
	assign GP_IN_DATA_OUT = filt_reg[8:5];
	assign PIN_FUNCTION_EXTERNAL_MEMORY_INTERFACE_OUT = (fn_reg == UAPM_FN_EXTERNAL_MEMORY_INTERFACE);

endmodule : uapm_top

/* File: design/uapm_cfg.svh */
`ifndef UAPM_CFG_SVH
`define UAPM_CFG_SVH

// Register offsets on the plain register port.
`define UAPM_OFS_BUS_CTRL 4'h0
`define UAPM_OFS_MEM_CTRL_ONE 4'h1
`define UAPM_OFS_MEM_CTRL_TWO 4'h2
`define UAPM_OFS_GP_DIR 4'h3
`define UAPM_OFS_GP_OUT 4'h4
`define UAPM_OFS_GP_IN 4'h5
`define UAPM_OFS_STATUS 4'h6

// Field positions.
`define UAPM_BIT_HOLDER_EN 0
`define UAPM_BIT_CLK_FLOAT 0
`define UAPM_BIT_ST_EXTERNAL_MEMORY_INTERFACE 0
`define UAPM_BIT_ST_HOLD 1
`define UAPM_BIT_ST_OFF 2
`define UAPM_BIT_ST_RUN 3

// Reset values.
`define UAPM_RST_HOLDER_EN 1'h1
`define UAPM_RST_CLK_FLOAT 1'h0
`define UAPM_RST_GP_DIR 4'h0
`define UAPM_RST_GP_OUT 4'h0
`define UAPM_RST_EXTERNAL_MEMORY_INTERFACE_OUT 4'h0

// Synchroniser depth for pin inputs.
`define UAPM_SYNC_STAGES 3

`endif

/* File: design/uapm_pkg.sv */
package uapm_pkg;

	// Function given to the upper address pins.
	typedef enum logic {
		UAPM_FN_GPIO,
		UAPM_FN_EXTERNAL_MEMORY_INTERFACE
	} uapm_fn_t;

	// Life cycle of the pin function.
	typedef enum logic {
		UAPM_ST_CAPTURE,
		UAPM_ST_RUN
	} uapm_state_t;

	// Pad control for the four upper address pins.
	typedef struct packed {
		logic [3:0] drive;
		logic [3:0] enable;
		logic [3:0] keep;
	} uapm_pad_t;

	// Pad control for the two memory clock outputs.
	typedef struct packed {
		logic [1:0] drive;
		logic [1:0] enable;
	} uapm_clk_pad_t;

	// Register port request.
	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} uapm_reg_req_t;

endpackage : uapm_pkg

/* File: tb/uapm_assertions.sv */
`timescale 1ns/10ps
module uapm_assertions (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic SYS_RST_IN,
	// Inputs watched
	input wire uapm_pkg::uapm_reg_req_t REG_REQ_IN,
	input wire logic BOOT_FUNCTION_STRAP_IN,
	input wire logic BUS_HOLD_IN,
	input wire logic TEST_RESET_N_IN,
	input wire logic EMULATION_PIN_ZERO_IN,
	input wire logic EMULATION_OFF_PIN_IN,
	input wire logic [3:0] EXTERNAL_MEMORY_INTERFACE_ADDR_IN,
	// Outputs watched
	input wire logic [15:0] REG_RDATA_OUT,
	input wire uapm_pkg::uapm_pad_t A_PAD_OUT,
	input wire uapm_pkg::uapm_clk_pad_t MEMORY_CLOCK_OUTPUT_OUT,
	input wire logic PIN_FUNCTION_EXTERNAL_MEMORY_INTERFACE_OUT
);
	import uapm_pkg::*;
	logic [1:0] age_reg;
	logic off;
	assign off = !TEST_RESET_N_IN && EMULATION_PIN_ZERO_IN && !EMULATION_OFF_PIN_IN;
	// Saturating edge count since release, so the strap check fires once per reset.
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			age_reg <= 2'h0;
		end else if (age_reg != 2'h3) begin
			age_reg <= age_reg + 2'h1;
		end
	end
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	sequence hold_seen; BUS_HOLD_IN[*7]; endsequence
	sequence off_seen; off[*7]; endsequence
	sequence quiet_seen; (age_reg == 2'h3 && !BUS_HOLD_IN && !off)[*7]; endsequence
	chk_rst_float: assert property (disable iff (1'b0) SYS_RST_IN |-> A_PAD_OUT.enable == 4'h0)
		else $error("pad driven in reset");
	chk_hold_float: assert property (hold_seen |-> A_PAD_OUT.enable == 4'h0)
		else $error("pad driven in hold");
	chk_off_float: assert property (off_seen |-> A_PAD_OUT.enable == 4'h0)
		else $error("pad driven in off mode");
	chk_clk_run: assert property (quiet_seen |-> MEMORY_CLOCK_OUTPUT_OUT.enable == 2'h3)
		else $error("memory clock not running");
	chk_external_memory_interface_drive: assert property (PIN_FUNCTION_EXTERNAL_MEMORY_INTERFACE_OUT && A_PAD_OUT.enable != 4'h0
		|-> A_PAD_OUT.enable == 4'hF && A_PAD_OUT.drive == $past(EXTERNAL_MEMORY_INTERFACE_ADDR_IN)) else $error("bad address drive");
	chk_keep_level: assert property ((A_PAD_OUT.keep & $past(A_PAD_OUT.keep)
		& (A_PAD_OUT.drive ^ $past(A_PAD_OUT.drive))) == 4'h0) else $error("held level moved");
	chk_keep_idle: assert property ((A_PAD_OUT.keep & A_PAD_OUT.enable) == 4'h0)
		else $error("holder on driven pin");
	chk_strap_take: assert property (age_reg == 2'h2 |-> PIN_FUNCTION_EXTERNAL_MEMORY_INTERFACE_OUT == BOOT_FUNCTION_STRAP_IN)
		else $error("strap not taken");
	chk_func_keep: assert property (age_reg == 2'h3 |-> $stable(PIN_FUNCTION_EXTERNAL_MEMORY_INTERFACE_OUT))
		else $error("function changed");
	chk_rdata_idle: assert property ($past(REG_REQ_IN.rd) || REG_RDATA_OUT == 16'h0)
		else $error("read data outside slot");
endmodule : uapm_assertions

/* File: tb/uapm_pin_model.sv */
`timescale 1ns/10ps
module uapm_pin_model (
	// Clock
	input wire logic clk_in,
	// Pad side and board side
	input wire uapm_pkg::uapm_pad_t pad_in,
	input wire logic [3:0] ext_drive_in,
	input wire logic [3:0] ext_en_in,
	// Wire level
	output logic [3:0] pin_out
);
	import uapm_pkg::*;
	logic [3:0] idle_reg = 4'h5;
	// A floating pin wanders so a stale level never passes for a driven one.
	always @(posedge clk_in) idle_reg <= ~idle_reg;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (pad_in.enable[i]) begin
				pin_out[i] = pad_in.drive[i];
			end else if (ext_en_in[i]) begin
				// A board driver overpowers the weak holder.
				pin_out[i] = ext_drive_in[i];
			end else if (pad_in.keep[i]) begin
				pin_out[i] = pad_in.drive[i];
			end else begin
				pin_out[i] = idle_reg[i];
			end
		end
	end
endmodule : uapm_pin_model

/* File: tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
	import uapm_pkg::*;
	logic clk = 1'b0;
	logic rst;
	logic strap = 1'b0, hold = 1'b0, trst_n = 1'b1, emulation_pin_zero = 1'b0, emuoff = 1'b1;
	logic [3:0] eaddr = 4'h0, ext_d = 4'h0, ext_en = 4'h0, pin, gpin;
	logic [1:0] msrc = 2'h1;
	logic [15:0] rdata;
	logic fn;
	uapm_reg_req_t req = '0;
	uapm_pad_t pad;
	uapm_clk_pad_t mclk;
	int error_cnt = 0, check_count = 0;
	uapm_top i_dut (.CLK_IN(clk), .SYS_RST_IN(rst), .REG_REQ_IN(req), .REG_RDATA_OUT(rdata), .A_PIN_IN(pin),
		.A_PAD_OUT(pad), .BOOT_FUNCTION_STRAP_IN(strap), .BUS_HOLD_IN(hold), .TEST_RESET_N_IN(trst_n),
		.EMULATION_PIN_ZERO_IN(emulation_pin_zero), .EMULATION_OFF_PIN_IN(emuoff), .EXTERNAL_MEMORY_INTERFACE_ADDR_IN(eaddr),
		.MEM_CLOCK_SRC_IN(msrc), .MEMORY_CLOCK_OUTPUT_OUT(mclk), .GP_IN_DATA_OUT(gpin), .PIN_FUNCTION_EXTERNAL_MEMORY_INTERFACE_OUT(fn));
	uapm_pin_model i_pins (.clk_in(clk), .pad_in(pad), .ext_drive_in(ext_d), .ext_en_in(ext_en), .pin_out(pin));
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) msrc <= ~msrc;
	task automatic cmp(input string w, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", w, e, g);
		end
	endtask : cmp
	task automatic cmp4(input string w, input logic [3:0] e, input logic [3:0] g);
		cmp(w, {12'h0, e}, {12'h0, g});
	endtask : cmp4
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		cmp("rdata", e, rdata);
	endtask : rd
	task automatic do_reset(input logic s);
		@(posedge clk);
		rst <= 1'b1;
		strap <= s;
		eaddr <= 4'h0;
		ext_en <= 4'h0;
		tick(16);
		cmp4("rst_en", 4'h0, pad.enable);
		@(posedge clk);
		rst <= 1'b0;
		tick(3);
		cmp4("func", {3'h0, s}, {3'h0, fn});
	endtask : do_reset
	task automatic sc_gp;
		do_reset(1'b0);
		cmp4("gp_en", 4'h0, pad.enable);
		cmp4("keep", 4'hF, pad.keep);
		rd(4'h6, 16'h0008);
		wr(4'h3, 16'h000A);
		wr(4'h4, 16'h000F);
		eaddr <= 4'hC;
		ext_en <= 4'h5;
		ext_d <= 4'h4;
		tick(8);
		cmp4("gp_en", 4'hA, pad.enable);
		cmp4("gp_drv", 4'hA, pad.drive & 4'hA);
		cmp4("gp_in", 4'h4, gpin & 4'h5);
		rd(4'h5, 16'h000E);
		rd(4'h3, 16'h000A);
		wr(4'h0, 16'h0000);
		tick(3);
		cmp4("keep", 4'h0, pad.keep);
		wr(4'h0, 16'h0001);
		tick(3);
		cmp4("keep", 4'h5, pad.keep);
		rd(4'h0, 16'h0001);
		rd(4'hF, 16'h0000);
	endtask : sc_gp
	task automatic sc_external_memory_interface;
		do_reset(1'b1);
		cmp4("em_en", 4'hF, pad.enable);
		cmp4("em_drv", 4'h0, pad.drive);
		wr(4'h1, 16'h0001);
		strap <= 1'b0;
		eaddr <= 4'h9;
		hold <= 1'b1;
		tick(8);
		cmp4("hold_en", 4'h0, pad.enable);
		cmp4("held", 4'h9, pad.drive);
		cmp4("clk_en", 4'h2, {2'h0, mclk.enable});
		cmp4("clk_drv", {2'h0, ~msrc}, {2'h0, mclk.drive});
		rd(4'h6, 16'h000B);
		@(posedge clk);
		hold <= 1'b0;
		eaddr <= 4'h6;
		tick(8);
		cmp4("em_drv", 4'h6, pad.drive);
		cmp4("func", 4'h1, {3'h0, fn});
		wr(4'h1, 16'h0000);
		wr(4'h2, 16'h0001);
		hold <= 1'b1;
		rd(4'h2, 16'h0001);
		tick(6);
		cmp4("clk_en", 4'h1, {2'h0, mclk.enable});
		@(posedge clk);
		hold <= 1'b0;
		trst_n <= 1'b0;
		emulation_pin_zero <= 1'b1;
		emuoff <= 1'b0;
		tick(8);
		cmp4("off_en", 4'h0, pad.enable);
		rd(4'h6, 16'h000D);
		@(posedge clk);
		trst_n <= 1'b1;
		emulation_pin_zero <= 1'b0;
		emuoff <= 1'b1;
		tick(10);
	endtask : sc_external_memory_interface
	task automatic summarize;
		if (error_cnt == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : summarize
	initial begin
		rst = 1'b1;
		sc_gp;
		sc_external_memory_interface;
		summarize;
	end
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		summarize;
	end
endmodule : testbench
bind uapm_top uapm_assertions i_chk (.CLK_IN, .SYS_RST_IN, .REG_REQ_IN, .BOOT_FUNCTION_STRAP_IN, .BUS_HOLD_IN,
	.TEST_RESET_N_IN, .EMULATION_PIN_ZERO_IN, .EMULATION_OFF_PIN_IN, .EXTERNAL_MEMORY_INTERFACE_ADDR_IN, .REG_RDATA_OUT, .A_PAD_OUT,
	.MEMORY_CLOCK_OUTPUT_OUT, .PIN_FUNCTION_EXTERNAL_MEMORY_INTERFACE_OUT);
